// [rtl/node_switch_pkg.sv]
// Constants for the switch node configuration register bank.
// Assumes one clock domain; register numbers arrive on a plain request port.
// Functional notes
// - Registers reached only by config read/write
// - Identity register: boot pins, revision, version
// - Description register: links, attached, device processors
// - Bit 31 blocks all control register writes
// - Bit 8 blocks PLL register writes
// - Node identifier sixteen bits, reset zero
// - PLL register write resets the tile
// - PLL bit 31 suppresses the reset
// - PLL bit 30 skips waiting for relock
// - PLL bit 29 bypasses the PLL
// - PLL bit 28 forces boot over JTAG
// - PLL output, feedback, input divider fields
// - Switch clock ratio sixteen bits, reset zero
// - Reference clock ratio sixteen bits, reset three
// - User code: OTP code plus metal ID
// - Low mismatches route by low direction table
// - High mismatches route by high direction table
// - Config bit 1 lets debug line request
// - Config bit 0 lets tile drive line
// - Debug source records pin, tile1, tile0
package node_switch_pkg;
	localparam logic [7:0] REG_IDENT = 8'h00;
	localparam logic [7:0] REG_COUNTS = 8'h01;
	localparam logic [7:0] REG_PROTECT = 8'h04;
	localparam logic [7:0] REG_NODE_ID = 8'h05;
	localparam logic [7:0] REG_PLL = 8'h06;
	localparam logic [7:0] REG_SW_CLK = 8'h07;
	localparam logic [7:0] REG_REF_CLK = 8'h08;
	localparam logic [7:0] REG_JTAG_ID = 8'h09;
	localparam logic [7:0] REG_USER_CODE = 8'h0a;
	localparam logic [7:0] REG_DIRS_LOW = 8'h0c;
	localparam logic [7:0] REG_DIRS_HIGH = 8'h0d;
	localparam logic [7:0] REG_DBG_CFG0 = 8'h10;
	localparam logic [7:0] REG_DBG_CFG1 = 8'h11;
	localparam logic [7:0] REG_DBG_ORIGIN = 8'h1f;
	// Link register ranges: present in the map, contents not modelled
	localparam logic [7:0] REG_LINK_STATE_FIRST = 8'h20;
	localparam logic [7:0] REG_LINK_STATE_LAST = 8'h28;
	localparam logic [7:0] REG_CORE_LINK_FIRST = 8'h40;
	localparam logic [7:0] REG_CORE_LINK_LAST = 8'h47;
	localparam logic [7:0] REG_LINK_SETUP_FIRST = 8'h80;
	localparam logic [7:0] REG_LINK_SETUP_LAST = 8'h88;
	localparam logic [7:0] REG_FIXED_FWD_FIRST = 8'ha0;
	localparam logic [7:0] REG_FIXED_FWD_LAST = 8'ha7;
	// Field positions
	localparam int PROTECT_ALL_BIT = 31;
	localparam int PROTECT_PLL_BIT = 8;
	localparam int HEADER_MODE_BIT = 0;
	localparam int PLL_NO_RESET_BIT = 31;
	localparam int PLL_NO_RELOCK_BIT = 30;
	localparam int PLL_BYPASS_BIT = 29;
	localparam int PLL_JTAG_BOOT_BIT = 28;
	localparam int DBG_REQ_EN_BIT = 1;
	localparam int DBG_DRIVE_EN_BIT = 0;
	localparam int ORIGIN_PIN_BIT = 4;
	// Writable masks; everything else reads zero
	localparam logic [31:0] PROTECT_MASK = 32'h8000_0101;
	localparam logic [31:0] NODE_ID_MASK = 32'h0000_ffff;
	localparam logic [31:0] PLL_MASK = 32'hf39f_ff7f;
	localparam logic [31:0] RATIO_MASK = 32'h0000_ffff;
	localparam logic [31:0] DBG_CFG_MASK = 32'h0000_0003;
	localparam logic [31:0] ORIGIN_MASK = 32'h0000_0013;
	// Reset values
	localparam logic [31:0] PROTECT_RESET = 32'h0000_0000;
	localparam logic [31:0] NODE_ID_RESET = 32'h0000_0000;
	localparam logic [31:0] PLL_RESET = 32'h0000_0000;
	localparam logic [31:0] SW_CLK_RESET = 32'h0000_0000;
	localparam logic [31:0] REF_CLK_RESET = 32'h0000_0003;
	// Identity and resource figures; values arbitrary
	localparam logic [7:0] SWITCH_REVISION = 8'h01;
	localparam logic [7:0] SWITCH_VERSION = 8'h02;
	localparam logic [7:0] LINK_COUNT = 8'h08;
	localparam logic [7:0] ATTACHED_PROCS = 8'h02;
	localparam logic [7:0] DEVICE_PROCS = 8'h02;
	localparam logic [31:0] JTAG_ID_VALUE = 32'h1234_5001;
	localparam logic [17:0] METAL_ID_VALUE = 18'h0_0a5a;
	// Counter value at which the boot pins are taken, on the third edge after reset release
	localparam logic [1:0] BOOT_CAPTURE_DELAY = 2'h2;
endpackage : node_switch_pkg

// [rtl/node_switch_config_regs.sv]
// Switch node configuration registers, PLL control outputs, route lookup
// and shared debug line handling. Requests come from the switch on the
// same clock; boot pins, OTP code and the debug pin are asynchronous.
module node_switch_config_regs (
	input wire logic clock,
	input wire logic reset,
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [7:0] cfg_reg_num,
	input wire logic [31:0] cfg_wdata,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	output logic cfg_write_refused,
	input wire logic [7:0] boot_select_pins,
	input wire logic [13:0] otp_user_code,
	output logic one_byte_headers,
	output logic [15:0] node_id,
	output logic pll_apply,
	output logic tile_reset_req,
	output logic pll_skip_relock,
	output logic pll_bypass,
	output logic boot_from_jtag,
	output logic [2:0] pll_out_div,
	output logic [12:0] pll_fb_mul,
	output logic [6:0] pll_in_div,
	output logic [15:0] switch_clock_ratio,
	output logic [15:0] reference_clock_ratio,
	input wire logic route_req,
	input wire logic [15:0] route_dest,
	output logic route_valid,
	output logic route_local,
	output logic [3:0] route_dir,
	input wire logic [1:0] tile_in_debug_flag,
	output logic [1:0] tile_debug_req,
	input wire logic debug_line_n_in,
	output logic debug_line_n_out,
	output logic debug_line_n_oe
);
	logic cfg_ack_ff;
	logic [31:0] cfg_rdata_ff;
	logic refused_ff;
	logic [31:0] protect_ff;
	logic [31:0] node_id_ff;
	logic [31:0] pll_ff;
	logic pll_apply_ff;
	logic tile_reset_ff;
	logic [31:0] sw_clk_ff;
	logic [31:0] ref_clk_ff;
	logic [31:0] dirs_low_ff;
	logic [31:0] dirs_high_ff;
	logic [31:0] dbg_cfg0_ff;
	logic [31:0] dbg_cfg1_ff;
	logic [31:0] origin_ff;
	logic [7:0] boot_meta_ff;
	logic [7:0] boot_sync_ff;
	logic [7:0] boot_pins_ff;
	logic [1:0] boot_cnt_ff;
	logic boot_taken_ff;
	logic [13:0] otp_meta_ff;
	logic [13:0] otp_sync_ff;
	logic dbg_meta_ff;
	logic dbg_sync_ff;
	logic line_low_prev_ff;
	logic debug_oe_ff;
	logic [1:0] tile_req_ff;
	logic route_valid_ff;
	logic route_local_ff;
	logic [3:0] route_dir_ff;

	logic wr;
	logic rd;
	logic locked_all;
	logic wr_ok;
	logic pll_wr_ok;
	logic refuse;
	logic [1:0] drive_en;
	logic [1:0] req_en;
	logic [1:0] tile_drivers;
	logic line_low;
	logic debug_event;

	// Index of the highest set bit; a zero input returns index 0, which the caller ignores
	function automatic logic [3:0] top_mismatch(input logic [15:0] diff);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (diff[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : top_mismatch

	function automatic logic [3:0] nibble_of(input logic [31:0] word, input logic [2:0] sel);
		return word[{sel, 2'b00} +: 4];
	endfunction : nibble_of

	assign wr = cfg_req && cfg_write;
	assign rd = cfg_req && !cfg_write;
	assign locked_all = protect_ff[node_switch_pkg::PROTECT_ALL_BIT];
	assign wr_ok = wr && !locked_all;
	assign pll_wr_ok = wr_ok && (cfg_reg_num == node_switch_pkg::REG_PLL)
		&& !protect_ff[node_switch_pkg::PROTECT_PLL_BIT];
	assign refuse = wr && (locked_all || ((cfg_reg_num == node_switch_pkg::REG_PLL)
		&& protect_ff[node_switch_pkg::PROTECT_PLL_BIT]));
	assign drive_en = {dbg_cfg1_ff[node_switch_pkg::DBG_DRIVE_EN_BIT],
		dbg_cfg0_ff[node_switch_pkg::DBG_DRIVE_EN_BIT]};
	assign req_en = {dbg_cfg1_ff[node_switch_pkg::DBG_REQ_EN_BIT],
		dbg_cfg0_ff[node_switch_pkg::DBG_REQ_EN_BIT]};
	assign tile_drivers = tile_in_debug_flag & drive_en;
	assign line_low = !dbg_sync_ff;
	assign debug_event = line_low && !line_low_prev_ff;

	// Request handshake: one answer per request, next cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cfg_ack_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			cfg_ack_ff <= cfg_req;
			refused_ff <= refuse;
		end
	end

	// Writable control registers; a locked write leaves them unchanged
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			protect_ff <= node_switch_pkg::PROTECT_RESET;
			node_id_ff <= node_switch_pkg::NODE_ID_RESET;
			sw_clk_ff <= node_switch_pkg::SW_CLK_RESET;
			ref_clk_ff <= node_switch_pkg::REF_CLK_RESET;
			dirs_low_ff <= 32'h0000_0000;
			dirs_high_ff <= 32'h0000_0000;
			dbg_cfg0_ff <= 32'h0000_0000;
			dbg_cfg1_ff <= 32'h0000_0000;
		end else if (wr_ok) begin
			if (cfg_reg_num == node_switch_pkg::REG_PROTECT) begin
				protect_ff <= cfg_wdata & node_switch_pkg::PROTECT_MASK;
			end else if (cfg_reg_num == node_switch_pkg::REG_NODE_ID) begin
				node_id_ff <= cfg_wdata & node_switch_pkg::NODE_ID_MASK;
			end else if (cfg_reg_num == node_switch_pkg::REG_SW_CLK) begin
				sw_clk_ff <= cfg_wdata & node_switch_pkg::RATIO_MASK;
			end else if (cfg_reg_num == node_switch_pkg::REG_REF_CLK) begin
				ref_clk_ff <= cfg_wdata & node_switch_pkg::RATIO_MASK;
			end else if (cfg_reg_num == node_switch_pkg::REG_DIRS_LOW) begin
				dirs_low_ff <= cfg_wdata;
			end else if (cfg_reg_num == node_switch_pkg::REG_DIRS_HIGH) begin
				dirs_high_ff <= cfg_wdata;
			end else if (cfg_reg_num == node_switch_pkg::REG_DBG_CFG0) begin
				dbg_cfg0_ff <= cfg_wdata & node_switch_pkg::DBG_CFG_MASK;
			end else if (cfg_reg_num == node_switch_pkg::REG_DBG_CFG1) begin
				dbg_cfg1_ff <= cfg_wdata & node_switch_pkg::DBG_CFG_MASK;
			end
		end
	end

	// PLL setting; every accepted write applies it and, unless bit 31 is set, resets the tile
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pll_ff <= node_switch_pkg::PLL_RESET;
			pll_apply_ff <= 1'b0;
			tile_reset_ff <= 1'b0;
		end else begin
			pll_apply_ff <= pll_wr_ok;
			tile_reset_ff <= pll_wr_ok && !cfg_wdata[node_switch_pkg::PLL_NO_RESET_BIT];
			if (pll_wr_ok) begin
				pll_ff <= cfg_wdata & node_switch_pkg::PLL_MASK;
			end
		end
	end

	// Boot pins: synchronised, then taken once shortly after reset release
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			boot_meta_ff <= 8'h00;
			boot_sync_ff <= 8'h00;
			boot_pins_ff <= 8'h00;
			boot_cnt_ff <= 2'h0;
			boot_taken_ff <= 1'b0;
		end else begin
			boot_meta_ff <= boot_select_pins;
			boot_sync_ff <= boot_meta_ff;
			if (!boot_taken_ff) begin
				if (boot_cnt_ff == node_switch_pkg::BOOT_CAPTURE_DELAY) begin
					boot_pins_ff <= boot_sync_ff;
					boot_taken_ff <= 1'b1;
				end else begin
					boot_cnt_ff <= boot_cnt_ff + 2'h1;
				end
			end
		end
	end

	// OTP code is static after power-up but still crosses into this domain
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			otp_meta_ff <= 14'h0000;
			otp_sync_ff <= 14'h0000;
		end else begin
			otp_meta_ff <= otp_user_code;
			otp_sync_ff <= otp_meta_ff;
		end
	end

	// Read path; unmapped and link registers answer zero
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cfg_rdata_ff <= 32'h0000_0000;
		end else if (rd) begin
			if (cfg_reg_num == node_switch_pkg::REG_IDENT) begin
				cfg_rdata_ff <= {8'h00, boot_pins_ff, node_switch_pkg::SWITCH_REVISION,
					node_switch_pkg::SWITCH_VERSION};
			end else if (cfg_reg_num == node_switch_pkg::REG_COUNTS) begin
				cfg_rdata_ff <= {8'h00, node_switch_pkg::LINK_COUNT,
					node_switch_pkg::ATTACHED_PROCS, node_switch_pkg::DEVICE_PROCS};
			end else if (cfg_reg_num == node_switch_pkg::REG_PROTECT) begin
				cfg_rdata_ff <= protect_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_NODE_ID) begin
				cfg_rdata_ff <= node_id_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_PLL) begin
				cfg_rdata_ff <= pll_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_SW_CLK) begin
				cfg_rdata_ff <= sw_clk_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_REF_CLK) begin
				cfg_rdata_ff <= ref_clk_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_JTAG_ID) begin
				cfg_rdata_ff <= node_switch_pkg::JTAG_ID_VALUE;
			end else if (cfg_reg_num == node_switch_pkg::REG_USER_CODE) begin
				cfg_rdata_ff <= {otp_sync_ff, node_switch_pkg::METAL_ID_VALUE};
			end else if (cfg_reg_num == node_switch_pkg::REG_DIRS_LOW) begin
				cfg_rdata_ff <= dirs_low_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_DIRS_HIGH) begin
				cfg_rdata_ff <= dirs_high_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_DBG_CFG0) begin
				cfg_rdata_ff <= dbg_cfg0_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_DBG_CFG1) begin
				cfg_rdata_ff <= dbg_cfg1_ff;
			end else if (cfg_reg_num == node_switch_pkg::REG_DBG_ORIGIN) begin
				cfg_rdata_ff <= origin_ff;
			end else begin
				cfg_rdata_ff <= 32'h0000_0000;
			end
		end
	end

	// Route lookup: one answer the cycle after each request
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			route_valid_ff <= 1'b0;
			route_local_ff <= 1'b0;
			route_dir_ff <= 4'h0;
		end else begin
			route_valid_ff <= route_req;
			if (route_req) begin
				logic [15:0] diff;
				logic [3:0] idx;
				diff = route_dest ^ node_id_ff[15:0];
				idx = top_mismatch(diff);
				route_local_ff <= (diff == 16'h0000);
				if (diff == 16'h0000) begin
					route_dir_ff <= 4'h0;
				end else if (idx[3]) begin
					route_dir_ff <= nibble_of(dirs_high_ff, idx[2:0]);
				end else begin
					route_dir_ff <= nibble_of(dirs_low_ff, idx[2:0]);
				end
			end
		end
	end

	// Shared debug line: pin synchroniser and our own open-drain drive
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dbg_meta_ff <= 1'b1;
			dbg_sync_ff <= 1'b1;
			line_low_prev_ff <= 1'b0;
			debug_oe_ff <= 1'b0;
			tile_req_ff <= 2'b00;
		end else begin
			dbg_meta_ff <= debug_line_n_in;
			dbg_sync_ff <= dbg_meta_ff;
			line_low_prev_ff <= line_low;
			debug_oe_ff <= |tile_drivers;
			tile_req_ff <= debug_event ? req_en : 2'b00;
		end
	end

	// Origin of the last event; a new event beats a software write
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			origin_ff <= 32'h0000_0000;
		end else if (debug_event) begin
			origin_ff <= {27'h0000000, line_low && !debug_oe_ff, 2'b00,
				tile_in_debug_flag & drive_en};
		end else if (wr_ok && cfg_reg_num == node_switch_pkg::REG_DBG_ORIGIN) begin
			origin_ff <= cfg_wdata & node_switch_pkg::ORIGIN_MASK;
		end
	end

	assign cfg_ack = cfg_ack_ff;
	assign cfg_rdata = cfg_rdata_ff;
	assign cfg_write_refused = refused_ff;
	assign one_byte_headers = protect_ff[node_switch_pkg::HEADER_MODE_BIT];
	assign node_id = node_id_ff[15:0];
	assign pll_apply = pll_apply_ff;
	assign tile_reset_req = tile_reset_ff;
	assign pll_skip_relock = pll_ff[node_switch_pkg::PLL_NO_RELOCK_BIT];
	assign pll_bypass = pll_ff[node_switch_pkg::PLL_BYPASS_BIT];
	assign boot_from_jtag = pll_ff[node_switch_pkg::PLL_JTAG_BOOT_BIT];
	assign pll_out_div = pll_ff[25:23];
	assign pll_fb_mul = pll_ff[20:8];
	assign pll_in_div = pll_ff[6:0];
	assign switch_clock_ratio = sw_clk_ff[15:0];
	assign reference_clock_ratio = ref_clk_ff[15:0];
	assign route_valid = route_valid_ff;
	assign route_local = route_local_ff;
	assign route_dir = route_dir_ff;
	assign tile_debug_req = tile_req_ff;
	// Open drain: only ever pulls low
	assign debug_line_n_out = 1'b0;
	assign debug_line_n_oe = debug_oe_ff;

	default clocking dflt @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_ack_follows;
		cfg_req |=> cfg_ack ##1 (cfg_ack == $past(cfg_req));
	endproperty
	a_ack_follows: assert property (p_ack_follows)
		else $error("request not answered in one cycle");

	property p_ident_read;
		rd && cfg_reg_num == node_switch_pkg::REG_IDENT |=> cfg_rdata[31:24] == 8'h00
			&& cfg_rdata[15:0] == {node_switch_pkg::SWITCH_REVISION,
			node_switch_pkg::SWITCH_VERSION} && cfg_rdata[23:16] == $past(boot_pins_ff);
	endproperty
	a_ident_read: assert property (p_ident_read)
		else $error("identity read wrong");

	property p_lock_holds;
		wr && locked_all && cfg_reg_num == node_switch_pkg::REG_NODE_ID
			|=> $stable(node_id) && cfg_write_refused;
	endproperty
	a_lock_holds: assert property (p_lock_holds)
		else $error("locked write changed node id");

	property p_pll_lock;
		wr && cfg_reg_num == node_switch_pkg::REG_PLL
			&& protect_ff[node_switch_pkg::PROTECT_PLL_BIT]
			|=> $stable(pll_ff) && !tile_reset_req && !pll_apply;
	endproperty
	a_pll_lock: assert property (p_pll_lock)
		else $error("locked PLL register written");

	property p_header_mode;
		wr_ok && cfg_reg_num == node_switch_pkg::REG_PROTECT && cfg_wdata[0]
			|=> one_byte_headers;
	endproperty
	a_header_mode: assert property (p_header_mode)
		else $error("header mode not set");

	property p_tile_reset;
		pll_wr_ok && !cfg_wdata[node_switch_pkg::PLL_NO_RESET_BIT]
			|=> tile_reset_req && pll_apply ##1 (!tile_reset_req || $past(pll_wr_ok));
	endproperty
	a_tile_reset: assert property (p_tile_reset)
		else $error("PLL write did not pulse tile reset");

	property p_no_reset;
		pll_wr_ok && cfg_wdata[node_switch_pkg::PLL_NO_RESET_BIT]
			|=> !tile_reset_req && pll_apply;
	endproperty
	a_no_reset: assert property (p_no_reset)
		else $error("tile reset despite suppression");

	property p_route_local;
		route_req && route_dest == node_id |=> route_valid && route_local;
	endproperty
	a_route_local: assert property (p_route_local)
		else $error("matching destination not local");

	property p_route_high;
		route_req && route_dest[15] != node_id[15]
			|=> route_dir == $past(dirs_high_ff[31:28]) && !route_local;
	endproperty
	a_route_high: assert property (p_route_high)
		else $error("top mismatch used wrong direction");

	property p_origin;
		debug_event |=> origin_ff[1:0] == $past(tile_drivers)
			&& tile_debug_req == $past(req_en);
	endproperty
	a_origin: assert property (p_origin)
		else $error("debug origin not recorded");

	property p_reserved_zero;
		rd && cfg_reg_num == node_switch_pkg::REG_NODE_ID |=> cfg_rdata[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved node id bits not zero");

	c_pll_write: cover property (pll_wr_ok ##1 tile_reset_req);
	c_locked_write: cover property (wr && locked_all ##1 cfg_write_refused);
	c_debug_event: cover property (debug_event ##1 |tile_debug_req);
	c_route_low: cover property (route_req && route_dest[15:8] == node_id[15:8]
		&& route_dest != node_id ##1 route_valid);
endmodule : node_switch_config_regs

// [dv/debug_line_model.sv]
// Shared open-drain debug line with its pull-up and an outside source.
// Assumes the design's enable is high while it pulls the line low.
module debug_line_model (
	input wire logic oe,
	input wire logic ext_pull,
	output logic line_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up only wins while nobody pulls low
	assign line_n = !(oe || ext_pull);
endmodule : debug_line_model

// [dv/node_switch_config_regs_test.sv]
// Self-checking bench for the switch node configuration registers.
// Assumes the debug line model resolves the open-drain pin.
module node_switch_config_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, reset, cfg_req, cfg_write, cfg_ack, cfg_write_refused;
	logic [7:0] cfg_reg_num, boot_select_pins;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [13:0] otp_user_code;
	logic one_byte_headers, pll_apply, tile_reset_req, pll_skip_relock, pll_bypass;
	logic boot_from_jtag, route_req, route_valid, route_local;
	logic [15:0] node_id, switch_clock_ratio, reference_clock_ratio, route_dest;
	logic [2:0] pll_out_div;
	logic [12:0] pll_fb_mul;
	logic [6:0] pll_in_div;
	logic [3:0] route_dir;
	logic [1:0] tile_in_debug_flag, tile_debug_req;
	logic debug_line_n_in, debug_line_n_out, debug_line_n_oe, ext_pull;
	int n_fail, n_tests, cycles;

	node_switch_config_regs node_switch_config_regs_i (
		.clock(clock), .reset(reset), .cfg_req(cfg_req), .cfg_write(cfg_write),
		.cfg_reg_num(cfg_reg_num), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata), .cfg_write_refused(cfg_write_refused),
		.boot_select_pins(boot_select_pins), .otp_user_code(otp_user_code),
		.one_byte_headers(one_byte_headers), .node_id(node_id), .pll_apply(pll_apply),
		.tile_reset_req(tile_reset_req), .pll_skip_relock(pll_skip_relock),
		.pll_bypass(pll_bypass), .boot_from_jtag(boot_from_jtag),
		.pll_out_div(pll_out_div), .pll_fb_mul(pll_fb_mul), .pll_in_div(pll_in_div),
		.switch_clock_ratio(switch_clock_ratio),
		.reference_clock_ratio(reference_clock_ratio), .route_req(route_req),
		.route_dest(route_dest), .route_valid(route_valid), .route_local(route_local),
		.route_dir(route_dir), .tile_in_debug_flag(tile_in_debug_flag),
		.tile_debug_req(tile_debug_req), .debug_line_n_in(debug_line_n_in),
		.debug_line_n_out(debug_line_n_out), .debug_line_n_oe(debug_line_n_oe)
	);
	debug_line_model debug_line_model_i (
		.oe(debug_line_n_oe), .ext_pull(ext_pull), .line_n(debug_line_n_in)
	);

	initial clock = 1'b0;
	always #4 clock = !clock;
	// Whole sequence needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Idle cycle first: back-to-back calls never re-raise the strobe in one step
	task automatic cfg(input logic wr, input logic [7:0] rn, input logic [31:0] wd);
		@(negedge clock);
		cfg_req = 1'b1;
		cfg_write = wr;
		cfg_reg_num = rn;
		cfg_wdata = wd;
		@(negedge clock);
		cfg_req = 1'b0;
		chk({31'h0, cfg_ack}, 32'h1);
	endtask : cfg

	task automatic rd(input logic [7:0] rn, input logic [31:0] exp);
		cfg(1'b0, rn, 32'h0);
		chk(cfg_rdata, exp);
	endtask : rd

	task automatic wr(input logic [7:0] rn, input logic [31:0] wd, input logic refused);
		cfg(1'b1, rn, wd);
		chk({31'h0, cfg_write_refused}, {31'h0, refused});
	endtask : wr

	task automatic route(input logic [15:0] d, input logic loc, input logic [3:0] dir);
		@(negedge clock);
		route_req = 1'b1;
		route_dest = d;
		@(negedge clock);
		route_req = 1'b0;
		chk({26'h0, route_valid, route_local, route_dir}, {26'h0, 1'b1, loc, dir});
	endtask : route

	task automatic wait_req(input logic [1:0] exp);
		for (int i = 0; i < 8 && tile_debug_req === 2'b00; i++) begin
			@(negedge clock);
		end
		chk({30'h0, tile_debug_req}, {30'h0, exp});
	endtask : wait_req

	task automatic t_reset_vals();
		logic [7:0] rn [10];
		rn = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h1f};
		for (int i = 0; i < 10; i++) begin
			rd(rn[i], (rn[i] == 8'h08) ? 32'h3 : 32'h0);
		end
		chk({16'h0, reference_clock_ratio}, 32'h3);
	endtask : t_reset_vals

	task automatic t_ident();
		logic [31:0] id;
		id = {8'h0, 8'h5a, node_switch_pkg::SWITCH_REVISION, node_switch_pkg::SWITCH_VERSION};
		rd(8'h00, id);
		wr(8'h00, 32'hffff_ffff, 1'b0);
		rd(8'h00, id);
		rd(8'h01, {8'h0, node_switch_pkg::LINK_COUNT, node_switch_pkg::ATTACHED_PROCS,
			node_switch_pkg::DEVICE_PROCS});
		rd(8'h09, node_switch_pkg::JTAG_ID_VALUE);
		rd(8'h0a, {14'h2a5f, node_switch_pkg::METAL_ID_VALUE});
		wr(8'h30, 32'h1, 1'b0);
		rd(8'h30, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'ha7, 32'h0);
	endtask : t_ident

	task automatic t_masks();
		logic [7:0] rn [5];
		logic [31:0] mk [5];
		rn = '{8'h05, 8'h07, 8'h08, 8'h10, 8'h11};
		mk = '{32'hffff, 32'hffff, 32'hffff, 32'h3, 32'h3};
		for (int i = 0; i < 5; i++) begin
			wr(rn[i], 32'hffff_ffff, 1'b0);
			rd(rn[i], mk[i]);
		end
		chk({node_id, switch_clock_ratio}, 32'hffff_ffff);
		chk({16'h0, reference_clock_ratio}, 32'hffff);
		wr(8'h10, 32'h0, 1'b0);
		wr(8'h11, 32'h0, 1'b0);
	endtask : t_masks

	task automatic t_pll();
		wr(8'h06, 32'h5292_3445, 1'b0);
		chk({27'h0, pll_apply, tile_reset_req, pll_skip_relock, pll_bypass, boot_from_jtag},
			32'h1d);
		chk({9'h0, pll_out_div, pll_fb_mul, pll_in_div}, {9'h0, 3'h5, 13'h1234, 7'h45});
		rd(8'h06, 32'h5292_3445);
		// Reserved bits set on purpose
		wr(8'h06, 32'hac60_0080, 1'b0);
		chk({27'h0, pll_apply, tile_reset_req, pll_skip_relock, pll_bypass, boot_from_jtag},
			32'h12);
		rd(8'h06, 32'ha000_0000);
	endtask : t_pll

	task automatic t_header();
		wr(8'h04, 32'h1, 1'b0);
		chk({31'h0, one_byte_headers}, 32'h1);
		wr(8'h04, 32'h0, 1'b0);
		chk({31'h0, one_byte_headers}, 32'h0);
	endtask : t_header

	task automatic t_route();
		wr(8'h05, 32'h1234, 1'b0);
		wr(8'h0c, 32'h8765_4321, 1'b0);
		wr(8'h0d, 32'hfedc_ba98, 1'b0);
		// Low bit also flipped: only the top mismatch may count
		for (int k = 0; k < 16; k++) begin
			route(16'h1234 ^ ((16'h1 << k) | 16'h1), 1'b0, (k < 8) ? 4'(k + 1) : 4'(k));
		end
		route(16'h1234, 1'b1, 4'h0);
	endtask : t_route

	task automatic t_debug();
		wr(8'h10, 32'h3, 1'b0);
		tile_in_debug_flag = 2'b01;
		@(negedge clock);
		chk({31'h0, debug_line_n_oe}, 32'h1);
		chk({31'h0, debug_line_n_out}, 32'h0);
		wait_req(2'b01);
		rd(8'h1f, 32'h1);
		tile_in_debug_flag = 2'b00;
		wr(8'h11, 32'h2, 1'b0);
		repeat (4) @(negedge clock);
		chk({31'h0, debug_line_n_oe}, 32'h0);
		ext_pull = 1'b1;
		@(negedge clock);
		wait_req(2'b11);
		ext_pull = 1'b0;
		rd(8'h1f, 32'h10);
	endtask : t_debug

	task automatic t_protect();
		wr(8'h04, 32'h100, 1'b0);
		wr(8'h06, 32'h1, 1'b1);
		chk({31'h0, pll_apply}, 32'h0);
		rd(8'h06, 32'ha000_0000);
		wr(8'h05, 32'h7, 1'b0);
		wr(8'h04, 32'h8000_0101, 1'b0);
		wr(8'h05, 32'h9, 1'b1);
		rd(8'h05, 32'h7);
		wr(8'h04, 32'h0, 1'b1);
		rd(8'h04, 32'h8000_0101);
		// The lock holds until reset only
		reset = 1'b1;
		@(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		rd(8'h04, 32'h0);
	endtask : t_protect

	initial begin
		n_fail = 0;
		n_tests = 0;
		cycles = 0;
		reset = 1'b1;
		cfg_req = 1'b0;
		cfg_write = 1'b0;
		cfg_reg_num = 8'h00;
		cfg_wdata = 32'h0;
		boot_select_pins = 8'h5a;
		otp_user_code = 14'h2a5f;
		route_req = 1'b0;
		route_dest = 16'h0;
		tile_in_debug_flag = 2'b00;
		ext_pull = 1'b0;
		repeat (16) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		t_reset_vals();
		t_ident();
		t_masks();
		t_pll();
		t_header();
		t_route();
		t_debug();
		t_protect();
		conclude();
	end
endmodule : node_switch_config_regs_test
